//--- logic/mrtwo_ctrl_end.sv
// Controller end: Wishbone registers driving the command pins
`timescale 1ns/100ps
module mrtwo_ctrl_end
  import mrtwo_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Link
  mrtwo_link_if.ctrl       link
);

  // --------------------------------------------------------------
  // Registers and command strobes
  // --------------------------------------------------------------
  logic [31:0] cmdReg;
  logic [31:0] next_cmdReg;
  logic        modeSet;
  logic        next_modeSet;
  logic        writeCmd;
  logic        next_writeCmd;
  logic        ack;
  logic        next_ack;
  logic [31:0] rdData;
  logic [31:0] next_rdData;
  logic        req;
  logic        rejected;

  always_comb
  begin
    req = wb_cyc_i && wb_stb_i && !ack;
    next_ack = req;
    next_cmdReg = cmdReg;
    next_modeSet = 1'h0;
    next_writeCmd = 1'h0;
    next_rdData = rdData;
    // Reserved delay and termination codes are refused
    rejected = (wb_dat_i[CMD_CWD_LSB +: 3] > CWD_MAX_CODE)
            || (wb_dat_i[CMD_TERM_LSB +: 2] == TERM_RESERVED);
    if (req && wb_we_i && wb_adr_i == REG_CMD && wb_sel_i == 4'hF)
    begin
      if (!rejected)
      begin
        next_cmdReg = wb_dat_i;
        next_modeSet = 1'h1;
      end
    end
    if (req && wb_we_i && wb_adr_i == REG_WRITE)
      next_writeCmd = 1'h1;
    if (req && !wb_we_i)
    begin
      case (wb_adr_i)
        REG_CMD:    next_rdData = cmdReg;
        REG_STATUS: next_rdData = {31'h0, modeSet};
        default:    next_rdData = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmdReg   <= 32'h0;
      modeSet  <= 1'h0;
      writeCmd <= 1'h0;
      ack      <= 1'h0;
      rdData   <= 32'h0;
    end
    else
    begin
      cmdReg   <= next_cmdReg;
      modeSet  <= next_modeSet;
      writeCmd <= next_writeCmd;
      ack      <= next_ack;
      rdData   <= next_rdData;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdData;

  // --------------------------------------------------------------
  // Pins: unused bits zero, bank 010
  // --------------------------------------------------------------
  assign link.modeSet     = modeSet;
  assign link.writeCmd    = writeCmd;
  assign link.bank        = modeSet ? MODE_BANK_SEL : 3'h0;
  assign link.addr        = {2'h0, cmdReg[CMD_TERM_LSB +: 2], 1'h0,
                             cmdReg[CMD_TEMP_BIT], 1'h0,
                             cmdReg[CMD_CWD_LSB +: 3],
                             cmdReg[CMD_REFRESH_LSB +: 3]};
  assign link.additiveDelay = cmdReg[CMD_ADD_LSB +: 3];
  assign link.leveling    = cmdReg[CMD_LEVEL_BIT];
  assign link.selfRefresh = cmdReg[CMD_SELF_BIT];
endmodule

//--- logic/mrtwo_mem_end.sv
// Memory end: holds the second mode register and drives its consumers
//
// Overview of operation
// - Mode set with bank 010 loads register
// - Controller zeroes BA2, A8, A11, A12
// - A2:A0 selects self-refresh bank coverage
// - Only covered banks refreshed in self-refresh
// - Without self-refresh all banks stay valid
// - A5:A3 selects write delay five to nine
// - Data expected write delay cycles after command
// - Write delays are whole cycles only
// - Total write delay is additive plus cas
// - A10:A9 selects write termination strength
// - Write termination applies without nominal termination
// - Leveling suppresses dynamic termination switching
// - Termination switches for writes automatically
// - A7 selects self-refresh temperature range
// - Extended range doubles self-refresh rate
`timescale 1ns/100ps
module mrtwo_mem_end
  import mrtwo_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Link
  mrtwo_link_if.mem       link,
  // Nominal termination from the first mode register
  input  wire logic [1:0] nominalTerm,
  // Consumers
  output logic [7:0]      refreshBanks,
  output logic            refreshDouble,
  output logic [4:0]      totalWriteDelay,
  output logic            dataExpect,
  output logic [1:0]      activeTerm,
  output logic            writeTermOn
);

  // --------------------------------------------------------------
  // Mode register
  // --------------------------------------------------------------
  logic [2:0] refreshSel;
  logic [2:0] cwdCode;
  logic [1:0] termSel;
  logic       tempRange;
  logic [2:0] next_refreshSel;
  logic [2:0] next_cwdCode;
  logic [1:0] next_termSel;
  logic       next_tempRange;
  logic       hit;

  always_comb
  begin
    hit = link.modeSet && (link.bank == MODE_BANK_SEL);
    next_refreshSel = refreshSel;
    next_cwdCode    = cwdCode;
    next_termSel    = termSel;
    next_tempRange  = tempRange;
    if (hit)
    begin
      next_refreshSel = link.addr[REFRESH_LSB +: 3];
      next_cwdCode    = link.addr[CWD_LSB +: 3];
      next_termSel    = link.addr[TERM_LSB +: 2];
      next_tempRange  = link.addr[TEMP_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      refreshSel <= RESET_REFRESH;
      cwdCode    <= RESET_CWD;
      termSel    <= RESET_TERM;
      tempRange  <= RESET_TEMP;
    end
    else
    begin
      refreshSel <= next_refreshSel;
      cwdCode    <= next_cwdCode;
      termSel    <= next_termSel;
      tempRange  <= next_tempRange;
    end
  end

  // --------------------------------------------------------------
  // Refresh outputs
  // --------------------------------------------------------------
  logic [7:0] next_refreshBanks;
  logic       next_refreshDouble;

  always_comb
  begin
    // All banks kept unless self-refresh is running
    if (link.selfRefresh)
      next_refreshBanks = mrtwo_cover(refreshSel);
    else
      next_refreshBanks = 8'hFF;
    next_refreshDouble = tempRange;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      refreshBanks  <= 8'hFF;
      refreshDouble <= 1'h0;
    end
    else
    begin
      refreshBanks  <= next_refreshBanks;
      refreshDouble <= next_refreshDouble;
    end
  end

  // --------------------------------------------------------------
  // Write delay: shift register of write commands
  // --------------------------------------------------------------
  logic [31:0] wrPipe;
  logic [31:0] next_wrPipe;
  logic [4:0]  next_total;
  logic        next_dataExpect;

  always_comb
  begin
    next_total = 5'({1'h0, mrtwo_cwd(cwdCode)})
               + 5'({2'h0, link.additiveDelay});
    next_wrPipe = {wrPipe[30:0], link.writeCmd};
    // Whole cycles only; tap one earlier as output is registered
    next_dataExpect = wrPipe[totalWriteDelay - 5'h2];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPipe          <= 32'h0;
      totalWriteDelay <= 5'h5;
      dataExpect      <= 1'h0;
    end
    else
    begin
      wrPipe          <= next_wrPipe;
      totalWriteDelay <= next_total;
      dataExpect      <= next_dataExpect;
    end
  end

  // --------------------------------------------------------------
  // Termination select
  // --------------------------------------------------------------
  logic [1:0] next_activeTerm;
  logic       next_writeTermOn;
  logic       writing;

  always_comb
  begin
    writing = link.writeCmd || (|wrPipe[15:0]);
    next_writeTermOn = 1'h0;
    next_activeTerm  = nominalTerm;
    // Switches on its own per write, no mode set needed
    if (writing && (termSel != 2'h0) && !link.leveling)
    begin
      next_writeTermOn = 1'h1;
      next_activeTerm  = termSel;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      activeTerm  <= 2'h0;
      writeTermOn <= 1'h0;
    end
    else
    begin
      activeTerm  <= next_activeTerm;
      writeTermOn <= next_writeTermOn;
    end
  end
endmodule

//--- shared/mrtwo_link_if.sv
// Interface: command pins between controller and memory
`timescale 1ns/100ps
interface mrtwo_link_if;
  import mrtwo_pkg::*;
  logic                  modeSet;
  logic                  writeCmd;
  logic                  leveling;
  logic                  selfRefresh;
  logic [BANK_WIDTH-1:0] bank;
  logic [ADDR_WIDTH-1:0] addr;
  logic [2:0]            additiveDelay;
  modport ctrl (output modeSet, writeCmd, leveling, selfRefresh, bank, addr,
                additiveDelay);
  modport mem  (input modeSet, writeCmd, leveling, selfRefresh, bank, addr,
                additiveDelay);
endinterface

//--- shared/mrtwo_pkg.sv
// Package: encodings and layout of the second mode register
package mrtwo_pkg;
  // Field positions on the address pins
  localparam int REFRESH_LSB   = 0;
  localparam int CWD_LSB       = 3;
  localparam int TEMP_BIT      = 7;
  localparam int TERM_LSB      = 9;
  localparam int ADDR_WIDTH    = 13;
  localparam int BANK_WIDTH    = 3;
  // Bank address selecting this register
  localparam logic [2:0] MODE_BANK_SEL = 3'h2;
  // Values after reset: full array, delay 5, termination off, normal range
  localparam logic [2:0] RESET_REFRESH = 3'h0;
  localparam logic [2:0] RESET_CWD     = 3'h0;
  localparam logic [1:0] RESET_TERM    = 2'h0;
  localparam logic       RESET_TEMP    = 1'h0;
  // Write delay base, largest legal code and reserved termination code
  localparam logic [3:0] CWD_BASE      = 4'h5;
  localparam logic [2:0] CWD_MAX_CODE  = 3'h4;
  localparam logic [1:0] TERM_RESERVED = 2'h3;
  // Termination codes
  typedef enum logic [1:0] {
    MRTWO_TERM_NONE,
    MRTWO_TERM_RZQ4,
    MRTWO_TERM_RZQ2,
    MRTWO_TERM_HOLD
  } mrtwo_term_type;
  // Wishbone register offsets of the controller
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_WRITE  = 4'h8;
  // Command register field positions
  localparam int CMD_REFRESH_LSB = 0;
  localparam int CMD_CWD_LSB     = 4;
  localparam int CMD_TERM_LSB    = 8;
  localparam int CMD_TEMP_BIT    = 12;
  localparam int CMD_ADD_LSB     = 16;
  localparam int CMD_LEVEL_BIT   = 20;
  localparam int CMD_SELF_BIT    = 21;

  // Bank coverage mask of a refresh code, bit per bank
  function automatic logic [7:0] mrtwo_cover(input logic [2:0] code);
    case (code)
      3'h0:    mrtwo_cover = 8'hFF;
      3'h1:    mrtwo_cover = 8'h0F;
      3'h2:    mrtwo_cover = 8'h03;
      3'h3:    mrtwo_cover = 8'h01;
      3'h4:    mrtwo_cover = 8'hFC;
      3'h5:    mrtwo_cover = 8'hF0;
      3'h6:    mrtwo_cover = 8'hC0;
      default: mrtwo_cover = 8'h80;
    endcase
  endfunction

  // Whole-cycle write delay from its code
  function automatic logic [3:0] mrtwo_cwd(input logic [2:0] code);
    mrtwo_cwd = CWD_BASE + {1'h0, code};
  endfunction
endpackage

//--- verif/dram_mode_register_two_config_tb.sv
// Testbench: controller and memory ends joined over the link
`timescale 1ns/100ps
module dram_mode_register_two_config_tb;
  import mrtwo_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [3:0]  wbAdr = 4'h0;
  logic [3:0]  wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0;
  logic [31:0] wbDatR;
  logic        wbAck;
  logic [1:0]  nominalTerm = 2'h0;
  logic [7:0]  refreshBanks;
  logic        refreshDouble;
  logic [4:0]  totalWriteDelay;
  logic        dataExpect;
  logic [1:0]  activeTerm;
  logic        writeTermOn;
  logic [31:0] lastCmd = 32'h0;
  int          errors = 0;
  int          nTests = 0;
  longint      tWrite = 0;
  logic [4:0]  lastN = 5'h05;
  logic [7:0]  bankMask [8] = '{8'hFF, 8'h0F, 8'h03, 8'h01,
                             8'hFC, 8'hF0, 8'hC0, 8'h80};
  logic [31:0] bad [3] = '{32'h50, 32'h300, 32'h40};
  mrtwo_link_if link ();
  mrtwo_ctrl_end mrtwo_ctrl_end_inst (.clk(clk), .rstn(rstn),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .link(link));
  mrtwo_mem_end mrtwo_mem_end_inst (.clk(clk), .rstn(rstn), .link(link),
    .nominalTerm(nominalTerm), .refreshBanks(refreshBanks),
    .refreshDouble(refreshDouble), .totalWriteDelay(totalWriteDelay),
    .dataExpect(dataExpect), .activeTerm(activeTerm),
    .writeTermOn(writeTermOn));
  mrtwo_properties mrtwo_properties_inst (.clk(clk), .rstn(rstn),
    .modeSet(link.modeSet), .writeCmd(link.writeCmd), .bank(link.bank),
    .addr(link.addr), .additiveDelay(link.additiveDelay));
  always #2 clk = ~clk;
  always @(posedge clk)
    if (link.writeCmd === 1'b1)
      tWrite = $time;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", nTests, errors);
    if (errors == 0 && nTests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wbCycle(logic we, logic [3:0] adr, logic [31:0] dat,
                         logic [3:0] sel, output logic [31:0] rd);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDatW <= dat;
    @(posedge clk);
    while (wbAck !== 1'b1)
      @(posedge clk);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic programMode(logic [2:0] rf, logic [2:0] cw, logic [1:0] tm,
                             logic tp, logic [2:0] ad, logic lv, logic sr);
    logic [31:0] rd;
    logic [31:0] cmd;
    cmd = {10'h0, sr, lv, 1'h0, ad, 3'h0, tp, 2'h0, tm, 1'h0, cw, 1'h0, rf};
    wbCycle(1'b1, REG_CMD, cmd, 4'hF, rd);
    lastCmd = cmd;
    lastN = 5'h05 + {2'h0, cw} + {2'h0, ad};
    @(posedge clk);
    check("banks", refreshBanks, sr ? bankMask[rf] : 8'hFF);
    check("double", refreshDouble, tp);
    check("total", totalWriteDelay, lastN);
    wbCycle(1'b1, REG_WRITE, 32'h0, 4'hF, rd);
    repeat (2) @(posedge clk);
    check("term", activeTerm, (tm != 2'h0 && !lv) ? tm : nominalTerm);
    check("term on", writeTermOn, (tm != 2'h0 && !lv));
    @(posedge dataExpect);
    // Measured at the edge that samples the expectation high
    @(posedge clk);
    check("delay", 32'(($time - tWrite) / 4), lastN);
    check("expect high", dataExpect, 1'b1);
    @(posedge clk);
    check("expect low", dataExpect, 1'b0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] rd;
    void'($urandom(91));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check("reset banks", refreshBanks, 8'hFF);
    check("reset total", totalWriteDelay, 5'h05);
    for (int i = 0; i < 24; i++)
    begin
      nominalTerm <= 2'($urandom);
      if (i < 8)
        programMode(3'(i), 3'(i % 5), 2'(i % 3), i[0], 3'(i), i[1], 1'b1);
      else
        programMode(3'($urandom), 3'($urandom % 5), 2'($urandom % 3),
                    1'($urandom), 3'($urandom), 1'($urandom), 1'($urandom));
    end
    foreach (bad[k])
    begin
      wbCycle(1'b1, REG_CMD, bad[k], (k == 2) ? 4'h3 : 4'hF, rd);
      @(posedge clk);
      check("refused", totalWriteDelay, lastN);
      wbCycle(1'b0, REG_CMD, 32'h0, 4'hF, rd);
      check("refused cmd", rd, lastCmd);
    end
    wbCycle(1'b0, REG_WRITE, 32'h0, 4'hF, rd);
    check("write reg read", rd, 32'h0);
    wbCycle(1'b0, REG_STATUS, 32'h0, 4'hF, rd);
    check("status read", rd, 32'h0);
    wbCycle(1'b0, 4'hC, 32'h0, 4'hF, rd);
    check("spare read", rd, 32'h0);
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule

//--- verif/mrtwo_properties.sv
// Checker: properties of the command pins between the two ends
`timescale 1ns/100ps
module mrtwo_properties
  import mrtwo_pkg::*;
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rstn,
  // Link
  input wire logic                  modeSet,
  input wire logic                  writeCmd,
  input wire logic [BANK_WIDTH-1:0] bank,
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic [2:0]            additiveDelay
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Single-cycle strobes and rules on the command pins
  // ----------------------------------------
  sequence modeStrobe;
    modeSet ##1 !modeSet;
  endsequence
  sequence writeStrobe;
    writeCmd ##1 !writeCmd;
  endsequence
  mode_bank_a:
    assert property (modeSet |-> bank == MODE_BANK_SEL) else $error("bank");
  mode_pulse_a:
    assert property (modeSet |-> modeStrobe) else $error("mode pulse");
  write_pulse_a:
    assert property (writeCmd |-> writeStrobe) else $error("write pulse");
  rfu_zero_a:
    assert property (modeSet |-> addr[8] == 1'b0 && addr[12:11] == 2'h0)
    else $error("spare bits");
  cwd_legal_a:
    assert property (modeSet |-> addr[5:3] <= CWD_MAX_CODE) else $error("cwd");
  term_legal_a:
    assert property (modeSet |-> addr[10:9] != TERM_RESERVED)
    else $error("term");
  additive_sync_a:
    assert property ($changed(additiveDelay) |-> modeSet)
    else $error("additive");
  cmd_apart_a:
    assert property (!(modeSet && writeCmd)) else $error("overlap");
endmodule
